// ### hw/rdy_pkg.sv
// Purpose: shared constants and types for the bus ready logic
// Assumes: one clock (bus_phase_clock domain), synchronous reset
// Notes: ready signals are active low on the link
package rdy_pkg;
    localparam int unsigned WAIT_W = 3;
    localparam logic [2:0] WAIT_MAX = 3'h7;
    localparam logic [2:0] WAIT_ZERO = 3'h0;
    localparam int unsigned NUM_REGIONS = 4;
    localparam logic [1:0] REGION_NONE = 2'h0;
    localparam int NUM_BUSES = 2;
    localparam logic [1:0] BUSES_IDLE_N = 2'h3;
    localparam logic [1:0] BUSES_NONE = 2'h0;
    localparam logic [2:0] WAIT_STEP = 3'h1;

    typedef enum logic [1:0]
    {
        RDY_MODE_INT = 2'h0,
        RDY_MODE_EXT = 2'h1,
        RDY_MODE_OR = 2'h2,
        RDY_MODE_AND = 2'h3
    } rdy_mode_t;

    typedef enum logic [1:0]
    {
        RDY_ST_IDLE = 2'h0,
        RDY_ST_WAIT = 2'h1,
        RDY_ST_HOLD = 2'h2
    } rdy_state_t;
endpackage

// ### hw/rdy_link_if.sv
// Purpose: link between processor bus ends and external ready logic
// Assumes: per bus one active-low strobe, a region code and one ready_n
// Notes: index 0 is the primary bus, index 1 the expansion bus
`timescale 1ns/1ps
interface rdy_link_if;
    logic [1:0] strobe_n;
    logic [1:0] region_0;
    logic [1:0] region_1;
    logic [1:0] ready_n;

    modport proc
    (
        output strobe_n,
        output region_0,
        output region_1,
        input ready_n
    );

    modport ext
    (
        input strobe_n,
        input region_0,
        input region_1,
        output ready_n
    );
endinterface

// ### hw/rdy_ctl.sv
// Purpose: ready control for one bus: wait counter combined with ready_n
// Assumes: strobe_n low for the whole cycle; cycle ends on done pulse
// Notes: two copies live in the processor end, one per bus
`timescale 1ns/1ps
module rdy_ctl
(
    input wire logic clk,
    input wire logic rst,
    input wire rdy_pkg::rdy_mode_t mode,
    input wire logic [2:0] wait_count,
    input wire logic start,
    input wire logic ext_ready_n,
    output logic done
);
    rdy_pkg::rdy_state_t state_q;
    rdy_pkg::rdy_state_t state_d;
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic int_ready_n;
    logic ext_rdy;
    logic int_rdy;
    logic fin;

    // internal ready, active low like the pin
    assign int_ready_n = !((state_q == rdy_pkg::RDY_ST_HOLD) ||
        (state_q == rdy_pkg::RDY_ST_WAIT && count_q == rdy_pkg::WAIT_ZERO)); // R4 R19
    assign ext_rdy = !ext_ready_n; // R4 R13
    assign int_rdy = !int_ready_n;

    always_comb
    begin
        case (mode)
            rdy_pkg::RDY_MODE_INT: fin = int_rdy;
            rdy_pkg::RDY_MODE_EXT: fin = ext_rdy; // R13
            rdy_pkg::RDY_MODE_OR: fin = int_rdy | ext_rdy; // R5 R7
            rdy_pkg::RDY_MODE_AND: fin = int_rdy & ext_rdy; // R9
            default: fin = int_rdy;
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        done = 1'b0;
        case (state_q)
            rdy_pkg::RDY_ST_IDLE:
            begin
                if (start)
                begin
                    state_d = rdy_pkg::RDY_ST_WAIT;
                    count_d = wait_count; // R3 R6 R19
                end
            end
            rdy_pkg::RDY_ST_WAIT:
            begin
                if (fin)
                begin
                    done = 1'b1;
                    state_d = rdy_pkg::RDY_ST_IDLE;
                end
                else if (count_q == rdy_pkg::WAIT_ZERO)
                begin
                    state_d = rdy_pkg::RDY_ST_HOLD; // R11
                end
                else
                begin
                    count_d = count_q - rdy_pkg::WAIT_STEP; // R19
                end
            end
            rdy_pkg::RDY_ST_HOLD:
            begin
                if (fin)
                begin
                    done = 1'b1;
                    state_d = rdy_pkg::RDY_ST_IDLE;
                end
            end
            default: state_d = rdy_pkg::RDY_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= rdy_pkg::RDY_ST_IDLE;
            count_q <= rdy_pkg::WAIT_ZERO;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end
endmodule

// ### hw/rdy_proc_end.sv
// Purpose: processor end: runs bus cycles on both buses with ready logic
// Assumes: user requests one cycle per bus with req pulse and region code
// Notes: each cycle has at least one strobe-low clock; done closes it
`timescale 1ns/1ps
// Behaviour
// R1 - separate ready logic for primary and expansion
// R2 - completion from counter, ready, AND or OR
// R3 - wait count applies to every external cycle
// R4 - both ready indications are active low
// R5 - OR mode ends on first ready
// R6 - counter supports up to seven waits
// R7 - OR mode: counter expiry ends unanswered cycle
// R8 - external logic restarts sequence each cycle
// R9 - AND mode ends when both ready
// R10 - AND mode needs external ready per device
// R11 - expired counter holds ready until external ready
// R12 - external per-region readies merged by one OR
// R13 - asserted ready input always completes cycle; code: only in RDY_MODE_EXT and RDY_MODE_OR, and in RDY_MODE_AND after counter expiry
// R14 - rest-asserted ready: slow devices deassert quickly
// R15 - rest-deasserted ready: select-driven or delayed ready
// R16 - one or two flops give one/two waits
// R17 - more waits: more stages or internal counter
// R18 - address space split into per-region selects
// R19 - counter loads, decrements, ready at zero
module rdy_proc_end
(
    input wire logic clk,
    input wire logic rst,
    rdy_link_if.proc link,
    input wire rdy_pkg::rdy_mode_t prim_mode,
    input wire logic [2:0] prim_wait,
    input wire logic prim_req,
    input wire logic [1:0] prim_region,
    output logic prim_busy,
    output logic prim_done,
    input wire rdy_pkg::rdy_mode_t exp_mode,
    input wire logic [2:0] exp_wait,
    input wire logic exp_req,
    input wire logic [1:0] exp_region,
    output logic exp_busy,
    output logic exp_done
);
    logic [1:0] strobe_n_q;
    logic [1:0] strobe_n_d;
    logic [1:0] busy_q;
    logic [1:0] busy_d;
    logic [1:0] reg0_q;
    logic [1:0] reg0_d;
    logic [1:0] reg1_q;
    logic [1:0] reg1_d;
    rdy_pkg::rdy_mode_t prim_mode_q;
    rdy_pkg::rdy_mode_t prim_mode_d;
    rdy_pkg::rdy_mode_t exp_mode_q;
    rdy_pkg::rdy_mode_t exp_mode_d;
    logic [1:0] done_q;
    logic [1:0] done_d;
    logic [1:0] start;
    logic [1:0] fin;
    logic [1:0] req;

    // an idle bus (strobe high) takes a pending request
    function automatic logic cycle_take(input logic line_n, input logic want);
        cycle_take = line_n && want;
    endfunction

    // an open cycle (strobe low) closes when its ready logic says done
    function automatic logic cycle_close(input logic line_n, input logic ends);
        cycle_close = !line_n && ends;
    endfunction

    assign req = {exp_req, prim_req};
    assign link.strobe_n = strobe_n_q;
    assign link.region_0 = reg0_q;
    assign link.region_1 = reg1_q;
    assign prim_busy = busy_q[0];
    assign exp_busy = busy_q[1];
    assign prim_done = done_q[0];
    assign exp_done = done_q[1];

    // a cycle starts the clock after the request is taken; a request
    // seen while busy is not stored and must be held, so back-to-back cycles always
    // leave one strobe-high clock for the external logic to restart
    always_comb
    begin
        strobe_n_d = strobe_n_q;
        start = rdy_pkg::BUSES_NONE;
        for (int i = 0; i < rdy_pkg::NUM_BUSES; i++)
        begin
            if (cycle_take(strobe_n_q[i], req[i]))
            begin
                strobe_n_d[i] = 1'b0;
                start[i] = 1'b1; // R3 R19
            end
            else if (cycle_close(strobe_n_q[i], fin[i]))
            begin
                strobe_n_d[i] = 1'b1; // R2
            end
        end
        busy_d = ~strobe_n_d;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strobe_n_q <= rdy_pkg::BUSES_IDLE_N;
            busy_q <= rdy_pkg::BUSES_NONE;
        end
        else
        begin
            strobe_n_q <= strobe_n_d;
            busy_q <= busy_d;
        end
    end

    // region codes are latched as a cycle opens and kept until the next
    always_comb
    begin
        reg0_d = reg0_q;
        reg1_d = reg1_q;
        if (start[0])
        begin
            reg0_d = prim_region; // R18
        end
        if (start[1])
        begin
            reg1_d = exp_region; // R18
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg0_q <= rdy_pkg::REGION_NONE;
            reg1_q <= rdy_pkg::REGION_NONE;
        end
        else
        begin
            reg0_q <= reg0_d;
            reg1_q <= reg1_d;
        end
    end

    // mode is held for the whole cycle, so a change at the inputs
    // while a cycle is open cannot retime or cut short that cycle
    always_comb
    begin
        prim_mode_d = prim_mode_q;
        exp_mode_d = exp_mode_q;
        if (start[0])
        begin
            prim_mode_d = prim_mode; // R2
        end
        if (start[1])
        begin
            exp_mode_d = exp_mode; // R2
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prim_mode_q <= rdy_pkg::RDY_MODE_INT;
            exp_mode_q <= rdy_pkg::RDY_MODE_INT;
        end
        else
        begin
            prim_mode_q <= prim_mode_d;
            exp_mode_q <= exp_mode_d;
        end
    end

    // done rises with the strobe, one clock after the close
    always_comb
    begin
        done_d = rdy_pkg::BUSES_NONE;
        for (int i = 0; i < rdy_pkg::NUM_BUSES; i++)
        begin
            done_d[i] = cycle_close(strobe_n_q[i], fin[i]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done_q <= rdy_pkg::BUSES_NONE;
        end
        else
        begin
            done_q <= done_d;
        end
    end

    // independent copies, one per bus
    rdy_ctl u_prim_rdy // R1 R2
    (
        .clk(clk),
        .rst(rst),
        .mode(prim_mode_q),
        .wait_count(prim_wait),
        .start(start[0]),
        .ext_ready_n(link.ready_n[0]),
        .done(fin[0])
    );

    rdy_ctl u_exp_rdy // R1 R2
    (
        .clk(clk),
        .rst(rst),
        .mode(exp_mode_q),
        .wait_count(exp_wait),
        .start(start[1]),
        .ext_ready_n(link.ready_n[1]),
        .done(fin[1])
    );
endmodule

// ### hw/rdy_ext_end.sv
// Purpose: external ready generator for both buses
// Assumes: region code decoded from address; region 0 is unmapped
// Notes: ready_n rests high; zero-wait regions answer combinationally
`timescale 1ns/1ps
module rdy_ext_end
(
    input wire logic clk,
    input wire logic rst,
    rdy_link_if.ext link,
    input wire logic [3:0] zero_wait_en,
    input wire logic [3:0] one_wait_en,
    input wire logic [3:0] two_wait_en
);
    logic [1:0] st1_q;
    logic [1:0] st1_d;
    logic [1:0] st2_q;
    logic [1:0] st2_d;
    logic [1:0] rdy;
    logic [1:0] sel;
    logic [1:0] rg [2];

    assign rg[0] = link.region_0;
    assign rg[1] = link.region_1;

    // one select per region; unmapped regions never answer
    function automatic logic region_hit(input logic [1:0] r, input logic [3:0] en);
        region_hit = en[r] && (r != rdy_pkg::REGION_NONE); // R18
    endfunction

    always_comb
    begin
        for (int i = 0; i < rdy_pkg::NUM_BUSES; i++)
        begin
            sel[i] = !link.strobe_n[i];
            // delay chain restarts whenever the strobe is high
            st1_d[i] = sel[i] && !st1_q[i] ? 1'b1 : sel[i]; // R8 R16
            st2_d[i] = sel[i] && st1_q[i]; // R16
            // per-region timings merged in one OR
            rdy[i] = sel[i] && (region_hit(rg[i], zero_wait_en) ||
                (st1_q[i] && region_hit(rg[i], one_wait_en)) ||
                (st2_q[i] && region_hit(rg[i], two_wait_en))); // R12 R15 R10
        end
    end

    assign link.ready_n = ~rdy; // R4 R15

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st1_q <= rdy_pkg::BUSES_NONE;
            st2_q <= rdy_pkg::BUSES_NONE;
        end
        else
        begin
            st1_q <= st1_d;
            st2_q <= st2_d;
        end
    end
endmodule

// ### dv/rdy_link_asserts.sv
// Purpose: link checks for both ends of the ready logic
// Assumes: region 1 zero-wait, 2 one-wait, 3 two-wait
// Notes: bench never aims ext or and mode at region 0
`timescale 1ns/1ps
module rdy_link_asserts
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] strobe_n,
    input wire logic [1:0] region_0,
    input wire logic [1:0] region_1,
    input wire logic [1:0] ready_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_one;
        $fell(strobe_n[0]) && region_0 == 2'h2;
    endsequence
    sequence s_two;
        $fell(strobe_n[0]) && region_0 == 2'h3 ##1 !strobe_n[0];
    endsequence
    property p_rest;
        strobe_n[0] && $past(strobe_n[0]) |-> ready_n[0];
    endproperty
    a_rest: assert property (p_rest) else $error("ready active on idle bus");
    property p_zero0;
        !strobe_n[0] && region_0 == 2'h1 |-> !ready_n[0];
    endproperty
    a_zero0: assert property (p_zero0) else $error("zero-wait ready late");
    property p_zero1;
        !strobe_n[1] && region_1 == 2'h1 |-> !ready_n[1];
    endproperty
    a_zero1: assert property (p_zero1) else $error("expansion ready late");
    property p_one;
        s_one |-> ready_n[0] ##1 (strobe_n[0] || !ready_n[0]);
    endproperty
    a_one: assert property (p_one) else $error("one-wait timing");
    property p_two;
        s_two |-> ready_n[0] ##1 (strobe_n[0] || !ready_n[0]);
    endproperty
    a_two: assert property (p_two) else $error("two-wait timing");
    property p_bound0;
        (!strobe_n[0]) [*8] |=> strobe_n[0];
    endproperty
    a_bound0: assert property (p_bound0) else $error("cycle too long");
    property p_bound1;
        (!strobe_n[1]) [*8] |=> strobe_n[1];
    endproperty
    a_bound1: assert property (p_bound1) else $error("expansion too long");
    property p_keep;
        !strobe_n[0] && !$past(strobe_n[0]) |-> $stable(region_0);
    endproperty
    a_keep: assert property (p_keep) else $error("region moved");
endmodule

// ### dv/bus_wait_state_ready_logic_test.sv
// Purpose: self-checking bench for both ends of the ready logic
// Assumes: region 1 zero-wait, 2 one-wait, 3 two-wait, 0 unmapped
// Notes: ext and and modes never aim at region 0, which would stall
`timescale 1ns/1ps
module bus_wait_state_ready_logic_test;
    logic clk;
    logic rst;
    rdy_pkg::rdy_mode_t md [2];
    logic [2:0] wt [2];
    logic [1:0] rg [2];
    logic [1:0] req;
    wire logic [1:0] busy;
    wire logic [1:0] done;
    int n_fail;
    int samples_checked;
    rdy_link_if rdy_link_if_inst ();
    rdy_proc_end rdy_proc_end_inst
    (
        .clk(clk),
        .rst(rst),
        .link(rdy_link_if_inst),
        .prim_mode(md[0]),
        .prim_wait(wt[0]),
        .prim_req(req[0]),
        .prim_region(rg[0]),
        .prim_busy(busy[0]),
        .prim_done(done[0]),
        .exp_mode(md[1]),
        .exp_wait(wt[1]),
        .exp_req(req[1]),
        .exp_region(rg[1]),
        .exp_busy(busy[1]),
        .exp_done(done[1])
    );
    rdy_ext_end rdy_ext_end_inst
    (
        .clk(clk),
        .rst(rst),
        .link(rdy_link_if_inst),
        .zero_wait_en(4'h2),
        .one_wait_en(4'h4),
        .two_wait_en(4'h8)
    );
    rdy_link_asserts rdy_link_asserts_inst
    (
        .clk(clk),
        .rst(rst),
        .strobe_n(rdy_link_if_inst.strobe_n),
        .region_0(rdy_link_if_inst.region_0),
        .region_1(rdy_link_if_inst.region_1),
        .ready_n(rdy_link_if_inst.ready_n)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // waits taken: counter alone, ready alone, earlier or later of both
    function automatic int want_waits(int m, int w, int r);
        int e;
        e = (r == 0) ? 99 : r - 1;
        case (m)
            0: return w;
            1: return e;
            2: return (w < e) ? w : e;
            default: return (w > e) ? w : e;
        endcase
    endfunction
    task automatic bus_cycle(input int b, input int m, input int w, input int r, input int k);
        int n;
        n = 0;
        md[b] = rdy_pkg::rdy_mode_t'(m[1:0]);
        wt[b] = w[2:0];
        rg[b] = r[1:0];
        req[b] = 1'b1;
        @(posedge clk);
        #1;
        req[b] = 1'b0;
        while (busy[b] === 1'b1 && n < 20)
        begin
            check({31'h0, done[b]}, 32'h0);
            n++;
            @(posedge clk);
            #1;
        end
        check(n, k + 1);
        check({31'h0, done[b]}, 32'h1);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #50000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        rst = 1'b1;
        req = 2'h0;
        for (int b = 0; b < 2; b++)
        begin
            md[b] = rdy_pkg::RDY_MODE_INT;
            wt[b] = 3'h0;
            rg[b] = 2'h0;
        end
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int b = 0; b < 2; b++)
            for (int m = 0; m < 4; m++)
                for (int r = 0; r < 4; r++)
                    for (int w = 0; w < 8; w++)
                        if (r != 0 || m == 0 || m == 2)
                            bus_cycle(b, m, w, r, want_waits(m, w, r));
        $display("test sweep done");
        fork
            bus_cycle(0, 0, 7, 0, 7);
            bus_cycle(1, 1, 0, 3, 2);
        join
        $display("test both buses done");
        tally_and_finish();
    end
endmodule
